// ### src/imla_pkg.sv
// Constants and types for the two-wire memory port and lookup-table arbiter.
// Behaviour
// - A write keeps at most eight data bytes of one page.
// - More than eight bytes: the last eight received overwrite earlier ones.
// - Write address wraps to the start of the same eight-byte page.
// - Nonvolatile commit starts at STOP, then busy for the nonvolatile write time.
// - While busy the slave address is not acknowledged.
// - Reads start at the current address counter, with no address byte.
// - Random read uses a dummy write of the address, then repeated START.
// - During reads the address counter wraps from FFh to 00h.
// - The table controller waits and leaves the tables alone while the bus is active.
// - Readings go to hidden shadows, copied to visible bytes only when bus idle.
// - Loop: push readings and index, fetch offset and entry, compute, store output.
// - A long bus activity simply stalls the compensation loop.
// - Lower memory 00h-7Fh holds readings, status, control, output and power-on bytes.
// - Addresses 80h-FFh map onto the table chosen by the table select field.
// - Tables 04h-07h hold lookup table and offset for outputs 0 to 3.
// - Only table select codes 0100b-0111b select a table.
// - Power-on bytes act as ordinary nonvolatile memory with shadow disable clear.
// - With shadow disable set, power-on writes are volatile only, no busy time.
// - At power-on each power-on byte takes its last nonvolatile value.
// - Shadow disable is a mode register bit; zero enables nonvolatile writes.
// - An output follows a new value once its data byte is acknowledged.
package imla_pkg;
	localparam logic [4:0] DEV_BASE = 5'h16;
	localparam logic [6:0] A_CTRL = 7'h00;
	localparam logic [6:0] A_MODE = 7'h01;
	localparam logic [6:0] A_TIDX = 7'h03;
	localparam logic [6:0] A_TEMP = 7'h04;
	localparam logic [6:0] A_VCC = 7'h06;
	localparam logic [6:0] A_DAC3 = 7'h10;
	localparam logic [6:0] A_POR = 7'h78;
	localparam logic [6:0] OFS_IDX = 7'h7f;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h40;
	localparam int SEE_BIT = 7;
	localparam logic [1:0] TS_PREFIX = 2'h1;
	localparam logic [8:0] TEMP_OFS_C = 9'h028;
	localparam logic [6:0] IDX_MAX = 7'h46;
	localparam int CLK_MHZ = 100;
	localparam int NV_WRITE_TIME_US = 10000;
	localparam int NVW_CYC = NV_WRITE_TIME_US * CLK_MHZ;
	typedef enum logic [2:0] {B_IDLE = 3'h0, B_DEV = 3'h1, B_MEM = 3'h3,
		B_WR = 3'h2, B_RD = 3'h6} imla_bus_e;
	typedef enum logic [2:0] {L_IDLE = 3'h0, L_PUSH = 3'h1, L_FETCH = 3'h3,
		L_CALC = 3'h2, L_STORE = 3'h6} imla_lc_e;
endpackage

// ### src/imla_top.sv
// Two-wire slave memory port with page writes and lookup-table lockout.
`timescale 1ns/1ps
`default_nettype none
module imla_top
	import imla_pkg::*;
#(
	parameter int NV_WRITE_CYC = NVW_CYC
)
(
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// Two-wire bus
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	input wire logic [1:0] ADDR_PIN,
	// Conversion results
	input wire logic CONV_DONE,
	input wire logic [15:0] TEMP_CODE,
	input wire logic [15:0] VCC_CODE,
	// Outputs and status
	output logic [9:0] DAC0_VALUE,
	output logic [9:0] DAC1_VALUE,
	output logic [9:0] DAC2_VALUE,
	output logic [9:0] DAC3_VALUE,
	output logic BUS_ACTIVE,
	output logic NV_BUSY
);
	// ====================================================
	// Functions
	function automatic logic [6:0] calc_index(input logic [15:0] t);
		logic [8:0] c;
		c = 9'({t[15], t[15:8]} + TEMP_OFS_C);
		if (c[8])
			return 7'h00;
		else if (c[7:1] > IDX_MAX)
			return IDX_MAX;
		else
			return c[7:1];
	endfunction

	function automatic logic [6:0] dac_addr(input logic [1:0] ch);
		return 7'(A_DAC3 + 7'h06 - {4'h0, ch, 1'b0});
	endfunction

	// ====================================================
	// Storage
	logic [7:0] mem_lo [128];
	logic [7:0] tab [512];
	logic [7:0] por_nv [8];
	logic [7:0] pbuf [8];
	logic [9:0] dac_r [4];

	// ====================================================
	// Pin synchronisers
	logic [2:0] scl_s, sda_s;
	logic [5:0] ap_s;
	logic scl_f, sda_f, scl_p, sda_p;
	logic [1:0] ap_f;
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			ap_s <= 6'h00;
			scl_f <= 1'b1;
			sda_f <= 1'b1;
			scl_p <= 1'b1;
			sda_p <= 1'b1;
			ap_f <= 2'h0;
		end
		else
		begin
			scl_s <= {scl_s[1:0], SCL_I};
			sda_s <= {sda_s[1:0], SDA_I};
			ap_s <= {ap_s[3:0], ADDR_PIN};
			scl_f <= (scl_s[2] == scl_s[1]) ? scl_s[2] : scl_f;
			sda_f <= (sda_s[2] == sda_s[1]) ? sda_s[2] : sda_f;
			ap_f <= (ap_s[5:4] == ap_s[3:2]) ? ap_s[5:4] : ap_f;
			scl_p <= scl_f;
			sda_p <= sda_f;
		end
	end
	wire rise = scl_f & ~scl_p;
	wire fall = ~scl_f & scl_p;
	wire start_ev = scl_f & scl_p & sda_p & ~sda_f;
	wire stop_ev = scl_f & scl_p & ~sda_p & sda_f;

	// ====================================================
	// Bus decode
	imla_bus_e st_r;
	logic [3:0] bitc_r;
	logic [7:0] sh_r, tx_r, addr_r;
	logic oe_r, act_r, mack_r, init_r;
	logic [7:0] pval_r;
	logic [4:0] pg_r;
	logic [1:0] pt_r;
	logic [31:0] busy_r;
	wire busy = busy_r != 32'h0;
	wire [7:0] ctrl = mem_lo[A_CTRL];
	wire see = mem_lo[A_MODE][SEE_BIT];
	wire ts_ok = ctrl[3:2] == TS_PREFIX;
	wire dev_hit = sh_r[7:1] == {DEV_BASE, ap_f};
	wire [8:0] tab_a = {ctrl[1:0], addr_r[6:0]};
	wire [7:0] rd_byte = addr_r[7] ? (ts_ok ? tab[tab_a] : 8'h00) : mem_lo[addr_r[6:0]];
	wire byte_end = fall && bitc_r == 4'h7;
	wire ack_end = fall && bitc_r == 4'h8;
	wire wr_ev = byte_end && st_r == B_WR;
	wire rd_load = ack_end && ((st_r == B_DEV && oe_r && sh_r[0]) || (st_r == B_RD && mack_r));
	wire nv_tgt = addr_r[7] ? ts_ok : (addr_r[6:0] >= A_POR && !see);
	wire [7:0] wr_next = {addr_r[7:3], 3'(addr_r[2:0] + 3'h1)};
	wire commit = stop_ev && act_r && pval_r != 8'h00 && !busy;

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			st_r <= B_IDLE;
			bitc_r <= 4'h0;
			sh_r <= 8'h00;
			tx_r <= 8'h00;
			addr_r <= 8'h00;
			oe_r <= 1'b0;
			act_r <= 1'b0;
			mack_r <= 1'b0;
		end
		else if (start_ev)
		begin
			st_r <= B_DEV;
			// The SCL fall that closes the START is not a data bit; it wraps the count to zero.
			bitc_r <= 4'hf;
			oe_r <= 1'b0;
		end
		else if (stop_ev)
		begin
			st_r <= B_IDLE;
			oe_r <= 1'b0;
			act_r <= 1'b0;
		end
		else if (st_r != B_IDLE)
		begin
			if (rise && bitc_r != 4'h8)
				sh_r <= {sh_r[6:0], sda_f};
			if (rise && bitc_r == 4'h8)
				mack_r <= ~sda_f;
			if (byte_end)
			begin
				bitc_r <= 4'h8;
				unique case (st_r)
					B_DEV:
					begin
						oe_r <= dev_hit && !busy;
						act_r <= dev_hit && !busy;
					end
					B_MEM:
					begin
						oe_r <= 1'b1;
						addr_r <= sh_r;
					end
					B_WR:
					begin
						oe_r <= 1'b1;
						addr_r <= wr_next;
					end
					B_RD: oe_r <= 1'b0;
					B_IDLE: oe_r <= 1'b0;
				endcase
			end
			else if (ack_end)
			begin
				bitc_r <= 4'h0;
				if (rd_load)
				begin
					st_r <= B_RD;
					oe_r <= ~rd_byte[7];
					tx_r <= {rd_byte[6:0], 1'b0};
					addr_r <= 8'(addr_r + 8'h01);
				end
				else
				begin
					oe_r <= 1'b0;
					if (st_r == B_DEV && oe_r)
						st_r <= B_MEM;
					else if (st_r == B_MEM)
						st_r <= B_WR;
					else if (st_r != B_WR)
						st_r <= B_IDLE;
				end
			end
			else if (fall)
			begin
				bitc_r <= 4'(bitc_r + 4'h1);
				if (st_r == B_RD)
				begin
					oe_r <= ~tx_r[7];
					tx_r <= {tx_r[6:0], 1'b0};
				end
			end
		end
	end

	// ====================================================
	// Page buffer and nonvolatile commit
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			pval_r <= 8'h00;
			pg_r <= 5'h00;
			pt_r <= 2'h0;
			busy_r <= 32'h0;
			init_r <= 1'b1;
		end
		else
		begin
			init_r <= 1'b0;
			if (commit)
			begin
				pval_r <= 8'h00;
				busy_r <= 32'(NV_WRITE_CYC);
			end
			else if (busy)
				busy_r <= 32'(busy_r - 32'h1);
			if (wr_ev && nv_tgt)
			begin
				pval_r[addr_r[2:0]] <= 1'b1;
				pg_r <= addr_r[7:3];
				pt_r <= ctrl[1:0];
			end
		end
	end

	// Nonvolatile cells carry no reset; they keep their contents across RST_N.
	always_ff @(posedge SYS_CLK)
	begin
		if (wr_ev && nv_tgt)
			pbuf[addr_r[2:0]] <= sh_r;
		if (commit)
			for (int i = 0; i < 8; i++)
				if (pval_r[i])
				begin
					if (pg_r[4])
						tab[{pt_r, pg_r[3:0], 3'(i)}] <= pbuf[i];
					else
						por_nv[i] <= pbuf[i];
				end
	end

	// ====================================================
	// Table controller
	imla_lc_e lc_r;
	logic [1:0] ch_r;
	logic run_r;
	logic [7:0] lut_r, ofs_r;
	logic [9:0] val_r;
	logic [15:0] tsh_r, vsh_r;
	logic [6:0] ish_r;
	wire go = !act_r;
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			lc_r <= L_IDLE;
			ch_r <= 2'h0;
			run_r <= 1'b0;
			lut_r <= 8'h00;
			ofs_r <= 8'h00;
			val_r <= 10'h000;
			tsh_r <= 16'h0000;
			vsh_r <= 16'h0000;
			ish_r <= 7'h00;
		end
		else
		begin
			if (CONV_DONE)
			begin
				tsh_r <= TEMP_CODE;
				vsh_r <= VCC_CODE;
				ish_r <= calc_index(TEMP_CODE);
				run_r <= 1'b1;
			end
			if (go)
			begin
				unique case (lc_r)
					L_IDLE: lc_r <= run_r ? L_PUSH : L_IDLE;
					L_PUSH:
					begin
						lc_r <= L_FETCH;
						ch_r <= 2'h0;
					end
					L_FETCH:
					begin
						lut_r <= tab[{ch_r, ish_r}];
						ofs_r <= tab[{ch_r, OFS_IDX}];
						lc_r <= L_CALC;
					end
					L_CALC:
					begin
						val_r <= 10'({lut_r, 2'h0} + {2'h0, ofs_r});
						lc_r <= L_STORE;
					end
					L_STORE:
					begin
						lc_r <= (ch_r == 2'h3) ? L_PUSH : L_FETCH;
						ch_r <= 2'(ch_r + 2'h1);
					end
				endcase
			end
		end
	end

	// ====================================================
	// Lower memory, volatile view
	always_ff @(posedge SYS_CLK)
	begin
		if (init_r)
			for (int i = 0; i < 128; i++)
				mem_lo[i] <= (i == 1) ? MODE_RST : (i >= 120) ? por_nv[i - 120] : CTRL_RST;
		else if (wr_ev && !addr_r[7])
			mem_lo[addr_r[6:0]] <= sh_r;
		else if (go && lc_r == L_PUSH)
		begin
			mem_lo[A_TIDX] <= {1'b0, ish_r};
			mem_lo[A_TEMP] <= tsh_r[15:8];
			mem_lo[7'(A_TEMP + 7'h1)] <= tsh_r[7:0];
			mem_lo[A_VCC] <= vsh_r[15:8];
			mem_lo[7'(A_VCC + 7'h1)] <= vsh_r[7:0];
		end
		else if (go && lc_r == L_STORE)
		begin
			mem_lo[dac_addr(ch_r)] <= val_r[9:2];
			mem_lo[7'(dac_addr(ch_r) + 7'h1)] <= {val_r[1:0], 6'h00};
		end
	end

	// ====================================================
	// Output registers
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			for (int c = 0; c < 4; c++)
				dac_r[c] <= 10'h000;
			SDA_OE <= 1'b0;
			BUS_ACTIVE <= 1'b0;
			NV_BUSY <= 1'b0;
		end
		else
		begin
			for (int c = 0; c < 4; c++)
				dac_r[c] <= {mem_lo[dac_addr(2'(c))], mem_lo[7'(dac_addr(2'(c)) + 7'h1)][7:6]};
			SDA_OE <= oe_r;
			BUS_ACTIVE <= act_r;
			NV_BUSY <= busy;
		end
	end
	assign SDA_O = 1'b0;
	assign DAC0_VALUE = dac_r[0];
	assign DAC1_VALUE = dac_r[1];
	assign DAC2_VALUE = dac_r[2];
	assign DAC3_VALUE = dac_r[3];

	// ====================================================
	// Assertions
	sequence s_wr_ack;
		wr_ev && !addr_r[7] && addr_r[6:0] >= A_POR && see;
	endsequence
	property p_page_wrap;
		@(posedge SYS_CLK) disable iff (!RST_N)
		wr_ev |=> addr_r[7:3] == $past(addr_r[7:3]) && addr_r[2:0] == 3'($past(addr_r[2:0]) + 3'h1);
	endproperty
	a_page_wrap: assert property (p_page_wrap) else $error("write address left its page");
	property p_busy_nack;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(byte_end && st_r == B_DEV && busy && !start_ev && !stop_ev) |=> !oe_r ##1 !SDA_OE;
	endproperty
	a_busy_nack: assert property (p_busy_nack) else $error("address acknowledged while busy");
	property p_commit;
		@(posedge SYS_CLK) disable iff (!RST_N)
		commit |=> busy ##1 NV_BUSY;
	endproperty
	a_commit: assert property (p_commit) else $error("no busy period after commit");
	property p_vol_only;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(stop_ev && pval_r == 8'h00 && !busy) |=> !busy;
	endproperty
	a_vol_only: assert property (p_vol_only) else $error("busy after volatile write");
	property p_rd_wrap;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(rd_load && !start_ev && !stop_ev && addr_r == 8'hff) |=> addr_r == 8'h00;
	endproperty
	a_rd_wrap: assert property (p_rd_wrap) else $error("read counter did not wrap");
	property p_lockout;
		@(posedge SYS_CLK) disable iff (!RST_N)
		act_r |=> $stable(lc_r) && $stable(lut_r);
	endproperty
	a_lockout: assert property (p_lockout) else $error("table controller ran while bus active");
	property p_shadow;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(act_r && !wr_ev) |=> $stable(mem_lo[A_TIDX]);
	endproperty
	a_shadow: assert property (p_shadow) else $error("index pushed while bus active");
	property p_see;
		@(posedge SYS_CLK) disable iff (!RST_N)
		s_wr_ack |=> $stable(pval_r);
	endproperty
	a_see: assert property (p_see) else $error("shadow byte queued for commit");
	property p_dac_follow;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(wr_ev && addr_r == {1'b0, A_DAC3}) |=> ##1 DAC3_VALUE[9:2] == $past(sh_r, 2);
	endproperty
	a_dac_follow: assert property (p_dac_follow) else $error("output missed new value");
endmodule
`default_nettype wire

// ### testbench/imla_mst.sv
// Two-wire bus master model that drives the device's clock and data pins.
`timescale 1ns/1ps
`default_nettype none
module imla_mst
(
	// Clock
	input wire logic clk,
	// Device pull on the data line
	input wire logic dev_pull,
	// Bus lines
	output logic scl,
	output logic sda
);
	logic sda_m;
	// The data line has a pull-up, so it is low only while a party pulls it.
	assign sda = sda_m & ~dev_pull;
	initial
	begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Also serves as repeated start; the clock stands high between frames.
	task automatic start();
		cyc(4);
		sda_m = 1'b1;
		cyc(4);
		scl = 1'b1;
		cyc(8);
		sda_m = 1'b0;
		cyc(8);
		scl = 1'b0;
	endtask
	task automatic stop();
		cyc(4);
		sda_m = 1'b0;
		cyc(4);
		scl = 1'b1;
		cyc(8);
		sda_m = 1'b1;
		cyc(8);
	endtask
	// Data changes only while the clock is low and holds past the fall.
	task automatic bit_x(input logic b, output logic s);
		cyc(4);
		sda_m = b;
		cyc(4);
		scl = 1'b1;
		cyc(6);
		s = sda;
		cyc(2);
		scl = 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], s);
		bit_x(1'b1, s);
		ack = ~s;
	endtask
	// The last wanted byte is answered with a release, which frees the line.
	task automatic rbyte(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_x(1'b1, s);
			d[i] = s;
		end
		bit_x(~more, s);
	endtask
endmodule
`default_nettype wire

// ### testbench/imla_top_tb.sv
// Self-checking bench for the two-wire memory port and table arbiter.
`timescale 1ns/1ps
`default_nettype none
module imla_top_tb;
	import imla_pkg::*;
	logic clk, rst_n, scl, sda, sda_o, sda_oe, conv, busy, act, ack;
	logic [1:0] pins;
	logic [15:0] temp, vcc;
	logic [9:0] dac0, dac1, dac2, dac3, old;
	logic [7:0] b;
	logic [7:0] d[$];
	logic [7:0] e[$];
	logic [7:0] none[$];
	int n_mismatch, n_compared, n;
	imla_mst u_mst (.clk(clk), .dev_pull(sda_oe & ~sda_o), .scl(scl), .sda(sda));
	imla_top #(.NV_WRITE_CYC(400)) u_dut (.SYS_CLK(clk), .RST_N(rst_n), .SCL_I(scl),
		.SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .ADDR_PIN(pins), .CONV_DONE(conv),
		.TEMP_CODE(temp), .VCC_CODE(vcc), .DAC0_VALUE(dac0), .DAC1_VALUE(dac1),
		.DAC2_VALUE(dac2), .DAC3_VALUE(dac3), .BUS_ACTIVE(act), .NV_BUSY(busy));
	// ==========
	// Checking and bus tasks
	task automatic chk(input string what, input logic [9:0] ex, input logic [9:0] got);
		n_compared++;
		if (got !== ex)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, ex, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] q[$], input bit fin);
		u_mst.start();
		u_mst.wbyte({DEV_BASE, pins, 1'b0}, ack);
		chk("slave ack", 1'b1, ack);
		u_mst.wbyte(a, ack);
		chk("address ack", 1'b1, ack);
		foreach (q[i])
		begin
			u_mst.wbyte(q[i], ack);
			chk("data ack", 1'b1, ack);
		end
		if (fin)
			u_mst.stop();
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] q[$]);
		wr(a, none, 1'b0);
		u_mst.start();
		u_mst.wbyte({DEV_BASE, pins, 1'b1}, ack);
		chk("read slave ack", 1'b1, ack);
		foreach (q[i])
		begin
			u_mst.rbyte(i != q.size() - 1, b);
			chk("read byte", {2'h0, q[i]}, {2'h0, b});
		end
		u_mst.stop();
	endtask
	// Repeated addressing is bounded; running out of tries ends the run.
	task automatic poll();
		n = 0;
		ack = 1'b0;
		while (ack !== 1'b1 && n < 40)
		begin
			u_mst.start();
			u_mst.wbyte({DEV_BASE, pins, 1'b0}, ack);
			u_mst.stop();
			if (ack !== 1'b1)
				n++;
		end
		if (ack !== 1'b1)
		begin
			n_mismatch++;
			conclude();
		end
	endtask
	task automatic reset_dut();
		rst_n = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
		u_mst.cyc(10);
	endtask
	task automatic conv_pulse();
		@(posedge clk);
		#1;
		conv = 1'b1;
		u_mst.cyc(1);
		conv = 1'b0;
	endtask
	task automatic conclude();
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ==========
	// Stimulus
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		{rst_n, conv, n_mismatch, n_compared} = '0;
		pins = 2'h1;
		temp = 16'h0100;
		vcc = 16'h1234;
		reset_dut();
		chk("busy after reset", 1'b0, busy);
		chk("output after reset", 10'h000, dac0);
		u_mst.start();
		u_mst.wbyte({DEV_BASE, ~pins, 1'b0}, ack);
		u_mst.stop();
		chk("foreign address ack", 1'b0, ack);
		$display("test foreign_address done");
		for (int k = 0; k < 10; k++)
			d.push_back(8'(8'h31 + 23 * k));
		wr(8'h10, d, 1'b0);
		chk("output 3 after wrap", {d[8], d[9][7:6]}, dac3);
		chk("output 0 on ack", {d[6], d[7][7:6]}, dac0);
		chk("output 1 on ack", {d[4], d[5][7:6]}, dac1);
		chk("output 2 on ack", {d[2], d[3][7:6]}, dac2);
		u_mst.stop();
		u_mst.cyc(3);
		chk("volatile write busy", 1'b0, busy);
		for (int j = 0; j < 8; j++)
			e.push_back(d[j < 2 ? j + 8 : j]);
		rd(8'h10, e);
		$display("test page_write done");
		wr(8'h00, '{8'h04}, 1'b1);
		wr(8'h94, '{8'h20}, 1'b1);
		poll();
		wr(8'hfe, '{8'ha5, 8'h5a}, 1'b0);
		chk("busy before stop", 1'b0, busy);
		u_mst.stop();
		chk("busy after stop", 1'b1, busy);
		poll();
		chk("address refused while busy", 1'b1, n > 0);
		rd(8'hfe, '{8'ha5, 8'h5a, CTRL_RST | 8'h04, MODE_RST});
		wr(8'h00, '{8'h08}, 1'b1);
		rd(8'hfe, '{8'h00});
		wr(8'h00, '{8'h04}, 1'b1);
		$display("test tables done");
		old = dac0;
		wr(8'h20, none, 1'b0);
		chk("bus active", 1'b1, act);
		conv_pulse();
		u_mst.cyc(300);
		chk("output held while bus active", old, dac0);
		u_mst.stop();
		for (int i = 0; i < 1000 && dac0 !== 10'h0da; i++)
			u_mst.cyc(1);
		chk("output after lockout", 10'h0da, dac0);
		rd(8'h03, '{8'h14, 8'h01, 8'h00, 8'h12, 8'h34});
		$display("test lockout done");
		wr({1'b0, A_POR}, '{8'h3c}, 1'b1);
		chk("shadow write busy", 1'b1, busy);
		poll();
		wr({1'b0, A_MODE}, '{MODE_RST | 8'h80}, 1'b1);
		wr({1'b0, A_POR}, '{8'h99}, 1'b1);
		u_mst.cyc(3);
		chk("shadow disabled busy", 1'b0, busy);
		rd({1'b0, A_POR}, '{8'h99});
		pins = 2'h2;
		reset_dut();
		rd({1'b0, A_POR}, '{8'h3c});
		u_mst.start();
		u_mst.wbyte({DEV_BASE, 2'h1, 1'b0}, ack);
		u_mst.stop();
		chk("old strap address ack", 1'b0, ack);
		$display("test shadow done");
		temp = 16'hf600;
		vcc = 16'h5678;
		conv_pulse();
		u_mst.cyc(20);
		rd(8'h03, '{8'h0f, 8'hf6, 8'h00, 8'h56, 8'h78});
		$display("test second_conversion done");
		conclude();
	end
endmodule
`default_nettype wire
